// *** sdc_i2c_slave.sv ***
`timescale 1ns/10ps
`default_nettype none

module sdc_i2c_slave (
	input  wire logic            core_clk,
	input  wire logic            reset_n,
	input  wire logic            clear,
	input  wire logic            scl_in,
	input  wire logic            sda_in,
	input  wire logic [1:0]      addr_sel_in,
	output logic                 sda_out,
	output logic                 sda_oe,
	output sdc_pkg::sdc_cfg_t    serial_cfg
);

	// Whole state of the slave
	typedef struct packed {
		sdc_pkg::sdc_i2c_pins_t sy1;      // First sync stage
		sdc_pkg::sdc_i2c_pins_t sy2;      // Second sync stage
		logic [1:0]             prv;      // Previous scl and sda
		sdc_pkg::sdc_i2c_st_t   st;       // Protocol state
		logic [3:0]             bitc;     // Bit counter
		logic [7:0]             sh;       // Shift register
		logic                   rw;       // Read request
		logic                   nack;     // Host refused more data
		logic [1:0]             ptr;      // Register pointer
		logic                   ptr_ok;   // Pointer byte received
		logic                   oe;       // Pulling sda low
		sdc_pkg::sdc_cfg_t      regs;     // Stored configuration
	} sdc_i2c_state_t;

	sdc_i2c_state_t st;                   // Registered state
	sdc_i2c_state_t next_st;              // Next state
	logic           scl_rise;             // Rising serial clock
	logic           scl_fall;             // Falling serial clock
	logic           start_c;              // Start condition
	logic           stop_c;               // Stop condition

	// Byte view of the configuration registers
	function automatic logic [7:0] rd_byte(input sdc_pkg::sdc_cfg_t c, input logic [1:0] i);
		case (i)
			sdc_pkg::REG_FB_LO: rd_byte = c.fb_div[7:0];
			sdc_pkg::REG_FB_HI: rd_byte = {6'h00, c.fb_div[9:8]};
			sdc_pkg::REG_POST:  rd_byte = {3'h0, c.pre_div, c.halver, c.post_sel};
			default:            rd_byte = 8'h00;
		endcase
	endfunction : rd_byte

	// Edges and bus conditions from the second stage onward only
	assign scl_rise = st.sy2.scl & ~st.prv[1];
	assign scl_fall = ~st.sy2.scl & st.prv[1];
	assign start_c  = st.sy2.scl & st.prv[1] & st.prv[0] & ~st.sy2.sda;
	assign stop_c   = st.sy2.scl & st.prv[1] & ~st.prv[0] & st.sy2.sda;

	// Protocol engine
	always_comb begin
		logic [7:0] b;
		b = 8'h00;
		next_st = st;
		next_st.sy1 = '{scl: scl_in, sda: sda_in, adr: addr_sel_in};
		next_st.sy2 = st.sy1;
		next_st.prv = {st.sy2.scl, st.sy2.sda};
		if (clear) begin
			// Master reset restores the defaults
			next_st.st   = sdc_pkg::I2C_IDLE;
			next_st.oe   = 1'b0;
			next_st.ptr  = 2'h0;
			next_st.regs = sdc_pkg::CFG_DEFAULT;
		end else if (start_c) begin
			next_st.st     = sdc_pkg::I2C_ADDR;
			next_st.bitc   = 4'h0;
			next_st.oe     = 1'b0;
			next_st.ptr_ok = 1'b0;
		end else if (stop_c) begin
			next_st.st = sdc_pkg::I2C_IDLE;
			next_st.oe = 1'b0;
		end else if (scl_rise) begin
			case (st.st)
				sdc_pkg::I2C_ADDR, sdc_pkg::I2C_WDATA: begin
					next_st.sh   = {st.sh[6:0], st.sy2.sda};
					next_st.bitc = st.bitc + 4'h1;
				end
				sdc_pkg::I2C_RACK: next_st.nack = st.sy2.sda;
				default: ;
			endcase
		end else if (scl_fall) begin
			case (st.st)
				sdc_pkg::I2C_ADDR: begin
					// Address follows the two select pins
					if (st.bitc == sdc_pkg::BITS_BYTE) begin
						if (st.sh[7:1] == {sdc_pkg::I2C_ADDR_HI, st.sy2.adr}) begin
							next_st.oe = 1'b1;
							next_st.rw = st.sh[0];
							next_st.st = sdc_pkg::I2C_AACK;
						end else begin
							next_st.st = sdc_pkg::I2C_IDLE;
						end
					end
				end
				sdc_pkg::I2C_AACK: begin
					if (st.rw) begin
						// Start read-back at the pointer
						b            = rd_byte(st.regs, st.ptr);
						next_st.oe   = ~b[7];
						next_st.sh   = {b[6:0], 1'b0};
						next_st.bitc = 4'h1;
						next_st.st   = sdc_pkg::I2C_RDATA;
					end else begin
						next_st.oe   = 1'b0;
						next_st.bitc = 4'h0;
						next_st.st   = sdc_pkg::I2C_WDATA;
					end
				end
				sdc_pkg::I2C_WDATA: begin
					if (st.bitc == sdc_pkg::BITS_BYTE) begin
						next_st.oe = 1'b1;
						next_st.st = sdc_pkg::I2C_WACK;
						if (!st.ptr_ok) begin
							next_st.ptr    = st.sh[1:0];
							next_st.ptr_ok = 1'b1;
						end else begin
							// Write lands in the addressed register
							case (st.ptr)
								sdc_pkg::REG_FB_LO: next_st.regs.fb_div[7:0] = st.sh;
								sdc_pkg::REG_FB_HI: next_st.regs.fb_div[9:8] = st.sh[1:0];
								sdc_pkg::REG_POST: begin
									next_st.regs.post_sel = st.sh[2:0];
									next_st.regs.halver   = st.sh[3];
									next_st.regs.pre_div  = st.sh[4];
								end
								default: ;
							endcase
							next_st.ptr = st.ptr + 2'h1;
						end
					end
				end
				sdc_pkg::I2C_WACK: begin
					next_st.oe   = 1'b0;
					next_st.bitc = 4'h0;
					next_st.st   = sdc_pkg::I2C_WDATA;
				end
				sdc_pkg::I2C_RDATA: begin
					if (st.bitc == sdc_pkg::BITS_BYTE) begin
						next_st.oe = 1'b0;
						next_st.st = sdc_pkg::I2C_RACK;
					end else begin
						next_st.oe   = ~st.sh[7];
						next_st.sh   = {st.sh[6:0], 1'b0};
						next_st.bitc = st.bitc + 4'h1;
					end
				end
				sdc_pkg::I2C_RACK: begin
					if (st.nack) begin
						next_st.st = sdc_pkg::I2C_IDLE;
					end else begin
						b            = rd_byte(st.regs, st.ptr + 2'h1);
						next_st.ptr  = st.ptr + 2'h1;
						next_st.oe   = ~b[7];
						next_st.sh   = {b[6:0], 1'b0};
						next_st.bitc = 4'h1;
						next_st.st   = sdc_pkg::I2C_RDATA;
					end
				end
				default: next_st.st = sdc_pkg::I2C_IDLE;
			endcase
		end
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			st      <= '0;
			st.sy1  <= '{scl: 1'b1, sda: 1'b1, adr: 2'h0};
			st.sy2  <= '{scl: 1'b1, sda: 1'b1, adr: 2'h0};
			st.prv  <= 2'h3;
			st.regs <= sdc_pkg::CFG_DEFAULT;
		end else begin
			st <= next_st;
		end
	end

	assign sda_out    = 1'b0;
	assign sda_oe     = st.oe;
	assign serial_cfg = st.regs;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n || clear);

	a_addr_match: assert property ($rose(sda_oe) && st.st == sdc_pkg::I2C_AACK
		|-> $past(st.sh[7:1]) == {sdc_pkg::I2C_ADDR_HI, $past(st.sy2.adr)})
		else $error("ack given to a foreign address");
	a_stop_release: assert property (stop_c |=> !sda_oe && st.st == sdc_pkg::I2C_IDLE)
		else $error("stop did not release the bus");
	c_serial_write: cover property (st.st == sdc_pkg::I2C_WACK && st.ptr_ok);

endmodule : sdc_i2c_slave

`default_nettype wire

// *** sdc_pkg.sv ***
package sdc_pkg;

	// Divider configuration set, shared by the pin path and the serial path
	typedef struct packed {
		logic [9:0] fb_div;           // Feedback divider value
		logic [2:0] post_sel;         // First post-divider selection
		logic       halver;           // Second output at half rate
		logic       pre_div;          // Reference pre-divider choice
	} sdc_cfg_t;

	// External pins of the core, sampled together through the synchroniser
	typedef struct packed {
		logic       iface;            // 1 selects the serial configuration
		logic       ref_sel;          // 1 selects the crystal reference
		logic       bypass;           // 1 bypasses the PLL
		logic [1:0] gate_n;           // Output stop inputs, low stops
		logic       mr;               // Master reset, high active
		logic       lock;             // Analog PLL lock flag
		logic       ref_clk;          // External reference clock
		logic       xtal;             // Crystal oscillator clock
		sdc_cfg_t   cfg;              // Parallel configuration pins
	} sdc_pins_t;

	// Serial port pins after sampling
	typedef struct packed {
		logic       scl;              // Serial clock
		logic       sda;              // Serial data
		logic [1:0] adr;              // Address select pins
	} sdc_i2c_pins_t;

	// Serial slave states
	typedef enum logic [2:0] {
		I2C_IDLE  = 3'h0,
		I2C_ADDR  = 3'h1,
		I2C_AACK  = 3'h2,
		I2C_WDATA = 3'h3,
		I2C_WACK  = 3'h4,
		I2C_RDATA = 3'h5,
		I2C_RACK  = 3'h6
	} sdc_i2c_st_t;

	// Configuration after reset: feedback 500, post select 2, full rate, pre 1
	localparam sdc_cfg_t CFG_DEFAULT = '{fb_div: 10'h1F4, post_sel: 3'h2,
		halver: 1'b0, pre_div: 1'b1};

	// Upper five address bits, value arbitrary
	localparam logic [4:0] I2C_ADDR_HI = 5'h1A;
	// Register indices of the serial port, and bits per byte
	localparam logic [1:0] REG_FB_LO = 2'h0;
	localparam logic [1:0] REG_FB_HI = 2'h1;
	localparam logic [1:0] REG_POST  = 2'h2;
	localparam logic [3:0] BITS_BYTE = 4'h8;

	// Largest post-divider selection and half period ceiling
	localparam logic [2:0] POST_SEL_MAX = 3'h5;
	localparam logic [5:0] HALF_MAX     = 6'h20;

	// Lock hold-off after a configuration change
	localparam int CLK_NS     = 10;
	localparam int RELOCK_NS  = 10000;
	localparam logic [9:0] RELOCK_CYC = 10'(RELOCK_NS / CLK_NS);

endpackage : sdc_pkg

// *** sdc_synth_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Post-divider offers six ratios, 2 to 64
// - Post-divider output keeps half duty cycle
// - Second output runs full or half rate
// - Pin path takes feedback, post, halver, pre
// - Pin settings apply while the interface choice is 0, serial settings while it is 1
// - Serial slave writes and reads divider registers
// - Two pins set slave address bits
// - Interface choice input picks configuration source
// - Reference choice picks crystal or external clock
// - Reference pre-divided, then multiplied by feedback
// - Stop input low holds output low
// - Lock output reflects PLL lock
// - Bypass input puts PLL in static bypass
// - New settings accepted while running
// - Choice 1 serial, choice 0 pins
// - Reference choice 1 crystal, 0 external
// - Glitch-free stop guaranteed with halver off
module sdc_synth_ctrl (
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic        crystal_osc_in,
	input  wire logic        ref_clk_in,
	input  wire logic        ref_sel_in,
	input  wire logic [9:0]  feedback_div_in,
	input  wire logic [2:0]  first_post_divider_sel,
	input  wire logic        second_output_halver,
	input  wire logic        pre_div_in,
	input  wire logic        iface_sel_in,
	input  wire logic [1:0]  addr_sel_in,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	input  wire logic        bypass_sel_in,
	input  wire logic [1:0]  output_gate_n,
	input  wire logic        master_reset_in,
	input  wire logic        pll_lock_in,
	output logic [9:0]       pll_fb_div,
	output logic             pll_pre_div,
	output logic             pll_ref_sel,
	output logic             pll_bypass,
	output logic             primary_clock_out,
	output logic             secondary_clock_out,
	output logic             lock_indicator
);

	// Whole state of the core
	typedef struct packed {
		sdc_pkg::sdc_pins_t s1;     // First sync stage
		sdc_pkg::sdc_pins_t s2;     // Second sync stage
		logic               ref_q;  // Previous external reference
		logic               xtal_q; // Previous crystal clock
		sdc_pkg::sdc_cfg_t  cfg;    // Active configuration
		logic [5:0]         cnt;    // Half period counter
		logic               pa;     // Free-running first divider
		logic               pb;     // Free-running second divider
		logic               en_a;   // First output gate
		logic               en_b;   // Second output gate
		logic               qa;     // Gated first output
		logic               qb;     // Gated second output
		logic [9:0]         hold;   // Lock hold-off counter
		logic               lock;   // Lock indicator
	} sdc_core_t;

	sdc_core_t         st;          // Registered state
	sdc_core_t         next_st;     // Next state
	sdc_pkg::sdc_pins_t raw;        // Pins gathered for sampling
	sdc_pkg::sdc_cfg_t serial_cfg;  // Configuration held by the serial port
	logic [5:0]        half;        // Half period in source ticks
	logic              tick;        // Divider source enable

	// Half period for a post select, top ratio used for spare codes
	function automatic logic [5:0] half_of(input logic [2:0] sel);
		half_of = (sel > sdc_pkg::POST_SEL_MAX) ? sdc_pkg::HALF_MAX : (6'h01 << sel);
	endfunction : half_of

	assign raw = '{iface: iface_sel_in, ref_sel: ref_sel_in, bypass: bypass_sel_in,
		gate_n: output_gate_n, mr: master_reset_in, lock: pll_lock_in,
		ref_clk: ref_clk_in, xtal: crystal_osc_in,
		cfg: '{fb_div: feedback_div_in, post_sel: first_post_divider_sel,
			halver: second_output_halver, pre_div: pre_div_in}};

	// Serial configuration port
	sdc_i2c_slave u_i2c (
		.core_clk    (core_clk),
		.reset_n     (reset_n),
		.clear       (st.s2.mr),
		.scl_in      (scl_in),
		.sda_in      (sda_in),
		.addr_sel_in (addr_sel_in),
		.sda_out     (sda_out),
		.sda_oe      (sda_oe),
		.serial_cfg  (serial_cfg)
	);

	assign half = half_of(st.cfg.post_sel);

	// In bypass the divider counts reference edges, else every cycle stands for the VCO
	assign tick = !st.s2.bypass ? 1'b1 :
		(st.s2.ref_sel ? (st.s2.xtal & ~st.xtal_q) : (st.s2.ref_clk & ~st.ref_q));

	// Configuration select, dividers, gating and lock
	always_comb begin
		next_st        = st;
		next_st.s1     = raw;
		next_st.s2     = st.s1;
		next_st.ref_q  = st.s2.ref_clk;
		next_st.xtal_q = st.s2.xtal;
		if (st.s2.mr) begin
			// Master reset restores the default configuration and clears gates
			next_st.cfg  = sdc_pkg::CFG_DEFAULT;
			next_st.cnt  = 6'h00;
			next_st.pa   = 1'b0;
			next_st.pb   = 1'b0;
			next_st.en_a = 1'b0;
			next_st.en_b = 1'b0;
			next_st.qa   = 1'b0;
			next_st.qb   = 1'b0;
			next_st.hold = sdc_pkg::RELOCK_CYC;
			next_st.lock = 1'b0;
		end else begin
			// Choice low gives the pins, high the serial registers
			next_st.cfg = st.s2.iface ? serial_cfg : st.s2.cfg;
			if (next_st.cfg != st.cfg) begin
				next_st.hold = sdc_pkg::RELOCK_CYC;
				next_st.lock = 1'b0;
			end else if (st.hold != 10'h000) begin
				next_st.hold = st.hold - 10'h001;
				next_st.lock = 1'b0;
			end else begin
				next_st.lock = st.s2.lock;
			end
			// Equal half periods give an even duty cycle; >= catches a ratio cut on the fly
			if (tick) begin
				if (st.cnt >= half - 6'h01) begin
					next_st.cnt = 6'h00;
					next_st.pa  = ~st.pa;
				end else begin
					next_st.cnt = st.cnt + 6'h01;
				end
			end else if (st.cnt >= half) begin
				// A ratio cut between slow bypass ticks must not leave the count past the end
				next_st.cnt = 6'h00;
			end
			// Second output follows or halves the first, by the new halver so no stray move
			if (!next_st.cfg.halver) begin
				next_st.pb = next_st.pa;
			end else if (next_st.pa && !st.pa) begin
				next_st.pb = ~st.pb;
			end
			// Gates move only where the divider is low now or next, so no runt pulse
			if (!st.pa || !next_st.pa) begin
				next_st.en_a = st.s2.gate_n[0];
			end
			if (!st.pb || !next_st.pb) begin
				next_st.en_b = st.s2.gate_n[1];
			end
			next_st.qa = next_st.pa & next_st.en_a;
			next_st.qb = next_st.pb & next_st.en_b;
		end
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			st      <= '0;
			st.cfg  <= sdc_pkg::CFG_DEFAULT;
			st.hold <= sdc_pkg::RELOCK_CYC;
			// Pin stages start at the defaults, so no all-zero setting reaches the PLL
			st.s1.cfg <= sdc_pkg::CFG_DEFAULT;
			st.s2.cfg <= sdc_pkg::CFG_DEFAULT;
		end else begin
			st <= next_st;
		end
	end

	// Settings toward the analog PLL, then the clock outputs and lock indicator
	assign pll_fb_div          = st.cfg.fb_div;
	assign pll_pre_div         = st.cfg.pre_div;
	assign pll_ref_sel         = st.s2.ref_sel;
	assign pll_bypass          = st.s2.bypass;
	assign primary_clock_out   = st.qa;
	assign secondary_clock_out = st.qb;
	assign lock_indicator      = st.lock;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n || st.s2.mr);

	a_lock_after_change: assert property ($changed(st.cfg) |-> !lock_indicator [*8])
		else $error("lock shown right after a configuration change");
	a_lock_needs_pll: assert property (lock_indicator |-> $past(st.s2.lock))
		else $error("lock shown without PLL lock");
	a_stop_holds_low: assert property (!st.s2.gate_n[0] && !primary_clock_out
		|=> !primary_clock_out)
		else $error("stopped output went high");
	a_half_duty: assert property (st.cnt < half || $changed(st.cfg.post_sel))
		else $error("half period counter overran");
	a_ratio_range: assert property ($onehot(half) && half <= sdc_pkg::HALF_MAX)
		else $error("post-divider ratio outside the six choices");
	a_second_half: assert property (st.cfg.halver && $changed(st.pb) |-> $rose(st.pa))
		else $error("halved output moved off a first output rise");
	a_pins_win: assert property (!st.s2.iface ##1 !st.s2.mr
		|-> st.cfg == $past(st.s2.cfg))
		else $error("pin configuration not applied");
	a_bypass_ref: assert property (st.s2.bypass && st.s2.ref_sel
		&& !(st.s2.xtal && !st.xtal_q) |-> !tick)
		else $error("bypass divider ticked without a crystal edge");

	c_bypass_run: cover property (st.s2.bypass && tick && $rose(st.pa));
	c_serial_cfg: cover property (st.s2.iface && $changed(st.cfg));
	c_output_stop: cover property ($fell(st.en_a) ##1 !primary_clock_out [*4]);
	c_relock: cover property ($rose(lock_indicator));

endmodule : sdc_synth_ctrl

`default_nettype wire

// *** sdc_i2c_host.sv ***
`timescale 1ns/10ps
`default_nettype none

// Behavioural serial host with a 160 ns bit period
// Its clock stands high between frames, so no edges leak outside transfers
module sdc_i2c_host (
	output var logic scl,       // Serial clock, idles high
	output var logic sda_oe,    // High pulls the data line low
	input  wire logic sda       // Resolved data line with pull-up
);
	// Idle bus: clock high, data released
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
	end

	// Start or repeated start: data falls while the clock is high
	task automatic start();
		sda_oe = 1'b0;
		#40 scl = 1'b1;
		#40 sda_oe = 1'b1;
		#40 scl = 1'b0;
		#40;
	endtask : start

	// Stop: data rises while the clock is high, clock then stands high
	task automatic stop();
		sda_oe = 1'b1;
		#40 scl = 1'b1;
		#40 sda_oe = 1'b0;
		#40;
	endtask : stop

	// One bit: data set while clock low, sampled in mid high phase
	task automatic xbit(input logic b, output logic r);
		sda_oe = !b;
		#40 scl = 1'b1;
		#40 r = sda;
		#40 scl = 1'b0;
		#40;
	endtask : xbit

	// Eight bits MSB first, then a ninth bit; ab high releases the line
	task automatic xbyte(input logic [7:0] d, input logic ab, output logic [7:0] q,
		output logic a);
		for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
		xbit(ab, a);
	endtask : xbyte
endmodule : sdc_i2c_host

`default_nettype wire

// *** sdc_synth_ctrl_tb.sv ***
`timescale 1ns/10ps
`default_nettype none

module sdc_synth_ctrl_tb;
	logic       core_clk, reset_n, xtal, refc, ref_sel, pre, halver, iface;
	logic       bypass, mr, lock_in, sda_oe_d, pa, pb, lock_ind, pll_pre, pll_rs, pll_bp;
	logic [9:0] fb, pll_fb;
	logic [2:0] post;
	logic [1:0] gate_n, adr; // Stop inputs and slave address pins
	logic [7:0] q;          // Last byte read by the host
	logic       a;          // Last ninth bit seen by the host
	wire logic  scl, h_oe, sda;
	int         error_cnt = 0;
	int         n_tests = 0;
	int         hi, lo, ca, cb;

	// Open-drain data line with pull-up
	assign sda = !(h_oe | sda_oe_d);

	// Core clock 100 MHz, crystal 60 ns, external reference 100 ns
	always #5 core_clk = ~core_clk;
	always #30 xtal = ~xtal;
	always #50 refc = ~refc;

	sdc_synth_ctrl uut (.core_clk(core_clk), .reset_n(reset_n), .crystal_osc_in(xtal),
		.ref_clk_in(refc), .ref_sel_in(ref_sel), .feedback_div_in(fb),
		.first_post_divider_sel(post), .second_output_halver(halver), .pre_div_in(pre),
		.iface_sel_in(iface), .addr_sel_in(adr), .scl_in(scl), .sda_in(sda),
		.sda_out(), .sda_oe(sda_oe_d), .bypass_sel_in(bypass), .output_gate_n(gate_n),
		.master_reset_in(mr), .pll_lock_in(lock_in), .pll_fb_div(pll_fb),
		.pll_pre_div(pll_pre), .pll_ref_sel(pll_rs), .pll_bypass(pll_bp),
		.primary_clock_out(pa), .secondary_clock_out(pb), .lock_indicator(lock_ind));

	sdc_i2c_host host (.scl(scl), .sda_oe(h_oe), .sda(sda));

	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t %s got %0h exp %0h", $time, m, got, exp);
		end
	endtask : chk

	// Verdict and end of run
	task automatic finish_test();
		$display("errors %0d checks %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : finish_test

	// Apply parallel pins, then let the synchroniser settle
	task automatic pins(input logic [9:0] f, input logic [2:0] p, input logic h);
		@(posedge core_clk);
		fb <= f;
		post <= p;
		halver <= h;
		repeat (6) @(posedge core_clk);
		@(negedge core_clk);
	endtask : pins

	// High and low time of one output in core cycles
	task automatic meas(input logic sec, output int h, output int l);
		h = 0;
		l = 0;
		for (int n = 0; n < 400 && (sec ? pb : pa) !== 1'b0; n++) @(negedge core_clk);
		for (int n = 0; n < 400 && (sec ? pb : pa) !== 1'b1; n++) @(negedge core_clk);
		while ((sec ? pb : pa) === 1'b1 && h < 400) begin
			h++;
			@(negedge core_clk);
		end
		while ((sec ? pb : pa) === 1'b0 && l < 400) begin
			l++;
			@(negedge core_clk);
		end
	endtask : meas

	// Host writes one byte and expects an acknowledge
	task automatic wb(input logic [7:0] d);
		host.xbyte(d, 1'b1, q, a);
		chk(a, 1'b0, "no ack");
	endtask : wb

	// Six ratios, spare code, half duty, second output full and half rate
	task automatic t_post();
		for (int s = 0; s < 6; s++) begin
			pins(10'h0AA, s[2:0], 1'b0);
			meas(1'b0, hi, lo);
			chk(hi, 1 << s, "primary high");
			chk(lo, 1 << s, "primary low");
			meas(1'b1, hi, lo);
			chk(hi, 1 << s, "secondary full");
		end
		pins(10'h0AA, 3'h6, 1'b0);
		meas(1'b0, hi, lo);
		chk(hi, 32'h20, "spare code ratio");
		pins(10'h0AA, 3'h1, 1'b1);
		meas(1'b1, hi, lo);
		chk(hi, 32'h4, "secondary half");
		chk(lo, 32'h4, "secondary half low");
		pins(10'h0AA, 3'h1, 1'b0);
	endtask : t_post

	// Stopping the first output, then the second
	task automatic t_gate();
		for (int g = 1; g <= 2; g++) begin
			@(posedge core_clk);
			gate_n <= 2'(3 - g);
			repeat (8) @(negedge core_clk);
			ca = 0;
			cb = 0;
			repeat (100) begin
				@(negedge core_clk);
				ca += (pa === 1'b1);
				cb += (pb === 1'b1);
			end
			chk((g == 1) ? ca : cb, 0, "stopped output ran");
			chk(((g == 1) ? cb : ca) > 0, 1, "running output stopped");
		end
		@(posedge core_clk);
		gate_n <= 2'h3;
	endtask : t_gate

	// Bypass with crystal then external reference
	task automatic t_bypass();
		@(posedge core_clk);
		bypass <= 1'b1;
		pins(10'h0AA, 3'h0, 1'b0);
		chk(pll_bp, 1'b1, "bypass flag");
		chk(pll_rs, 1'b1, "crystal chosen");
		meas(1'b0, hi, lo);
		chk(hi, 32'h6, "crystal tick");
		@(posedge core_clk);
		ref_sel <= 1'b0;
		pins(10'h0AA, 3'h0, 1'b0);
		chk(pll_rs, 1'b0, "external chosen");
		meas(1'b0, hi, lo);
		chk(hi, 32'hA, "external tick");
		@(posedge core_clk);
		bypass <= 1'b0;
		ref_sel <= 1'b1;
	endtask : t_bypass

	// Lock follows the PLL, drops on a change and returns after the hold-off
	task automatic t_lock();
		repeat (1010) @(negedge core_clk);
		chk(lock_ind, 1'b1, "lock not reached");
		@(posedge core_clk);
		lock_in <= 1'b0;
		repeat (4) @(negedge core_clk);
		chk(lock_ind, 1'b0, "lock without PLL");
		@(posedge core_clk);
		lock_in <= 1'b1;
		pre <= 1'b0;
		pins(10'h0BB, 3'h1, 1'b0);
		chk(lock_ind, 1'b0, "lock kept");
		chk(pll_fb, 10'h0BB, "pin feedback");
		chk(pll_pre, 1'b0, "pin pre");
		repeat (900) @(negedge core_clk);
		chk(lock_ind, 1'b0, "lock early");
		repeat (120) @(negedge core_clk);
		chk(lock_ind, 1'b1, "lock missing");
	endtask : t_lock

	// Serial write, read back, address pins, interface choice
	task automatic t_serial();
		@(posedge core_clk);
		iface <= 1'b1;
		repeat (6) @(negedge core_clk);
		chk(pll_fb, 10'h1F4, "serial default");
		host.start();
		wb(8'hD4);
		wb(8'h00);
		wb(8'h55);
		wb(8'h02);
		wb(8'h01);
		host.stop();
		@(negedge core_clk);
		chk(pll_fb, 10'h255, "serial feedback");
		chk(pll_pre, 1'b0, "serial pre");
		host.start();
		wb(8'hD4);
		wb(8'h00);
		host.start();
		wb(8'hD5);
		host.xbyte(8'hFF, 1'b0, q, a);
		chk(q, 8'h55, "read low");
		host.xbyte(8'hFF, 1'b1, q, a);
		chk(q, 8'h02, "read high");
		host.stop();
		host.start();
		host.xbyte(8'hD2, 1'b1, q, a);
		chk(a, 1'b1, "foreign address acked");
		host.stop();
		@(posedge core_clk);
		adr <= 2'h1;
		repeat (4) @(negedge core_clk);
		host.start();
		host.xbyte(8'hD2, 1'b1, q, a);
		chk(a, 1'b0, "moved address not acked");
		host.stop();
		@(posedge core_clk);
		iface <= 1'b0;
		repeat (6) @(negedge core_clk);
		chk(pll_fb, 10'h0BB, "pins lost priority");
		@(posedge core_clk);
		iface <= 1'b1;
		repeat (6) @(negedge core_clk);
		chk(pll_fb, 10'h255, "serial lost");
	endtask : t_serial

	// Master reset stops the outputs and restores defaults
	task automatic t_mr();
		@(posedge core_clk);
		mr <= 1'b1;
		repeat (4) @(negedge core_clk);
		chk(pa, 1'b0, "reset primary");
		chk(pb, 1'b0, "reset secondary");
		@(posedge core_clk);
		mr <= 1'b0;
		repeat (6) @(negedge core_clk);
		chk(pll_fb, 10'h1F4, "reset feedback");
		chk(pll_pre, 1'b1, "reset pre");
		chk(lock_ind, 1'b0, "reset lock");
	endtask : t_mr

	// Main sequence
	initial begin
		// The factory test-mode input has no pin here; the system keeps it low
		{core_clk, xtal, refc, reset_n, halver, iface, bypass, mr} = '0;
		{ref_sel, pre, lock_in} = 3'h7;
		adr = 2'h2;
		fb = 10'h0AA;
		post = 3'h2;
		gate_n = 2'h3;
		repeat (16) @(posedge core_clk);
		reset_n <= 1'b1;
		@(negedge core_clk);
		chk(pll_fb, 10'h1F4, "reset value");
		chk(lock_ind, 1'b0, "reset lock");
		t_post();
		t_gate();
		t_bypass();
		t_lock();
		t_serial();
		t_mr();
		finish_test();
	end

	// Watchdog well beyond the expected run
	initial begin
		#300000;
		error_cnt++;
		$display("BAD %0t watchdog expired", $time);
		finish_test();
	end
endmodule : sdc_synth_ctrl_tb

`default_nettype wire
